// File: tb/bie_exec_tb.sv
// Purpose: Self-checking bench for the jump and increment execution slice.
// Assumes: Zero-wait APB slave; results visible one cycle after the instruction edge.
// Notes: Each row preloads pc, status, accumulator and one file register over APB.
`timescale 1ns/1ps
module bie_exec_tb;
  localparam logic [7:0] acc_ofs = bie_pkg::BIE_OFS_ACC;
  localparam logic [7:0] st_ofs = bie_pkg::BIE_OFS_STATUS;
  localparam logic [7:0] pc_ofs = bie_pkg::BIE_OFS_PC;
  typedef struct packed {
    logic [11:0] w;
    logic [7:0] fv;
    logic [7:0] st;
    logic dacc;
    logic [7:0] ed;
    logic [7:0] es;
    logic [10:0] ep;
    logic edisc;
  } bie_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_valid, discard_prefetch, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] instr_word;
  logic [10:0] pc_out;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  bie_row_type rows [7];

  bie_exec u_bie_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_word(instr_word), .instr_valid(instr_valid), .pc_out(pc_out), .discard_prefetch(discard_prefetch));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic stop_test;
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Cuts a hang in an APB wait short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // Second word lands in the cycle a jump or taken skip must drop
  task automatic exe(input logic [11:0] w1, input logic v2, input logic [11:0] w2);
    @(posedge pclk);
    instr_word <= w1;
    instr_valid <= 1'b1;
    @(posedge pclk);
    instr_word <= w2;
    instr_valid <= v2;
    if (v2) begin
      @(posedge pclk);
      instr_valid <= 1'b0;
    end
    #1;
  endtask : exe

  initial begin
    {presetn, psel, penable, pwrite, instr_valid} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    instr_word = 12'h0;
    rows[0] = '{12'h2a3, 8'hff, 8'h00, 1'b0, 8'h00, 8'h04, 11'h011, 1'b0};
    rows[1] = '{12'h283, 8'h12, 8'h04, 1'b1, 8'h13, 8'h00, 11'h011, 1'b0};
    rows[2] = '{12'h3ff, 8'h41, 8'h04, 1'b0, 8'h42, 8'h04, 11'h011, 1'b0};
    rows[3] = '{12'h3df, 8'hff, 8'h00, 1'b1, 8'h00, 8'h00, 11'h011, 1'b1};
    rows[4] = '{12'ha05, 8'h33, 8'h40, 1'b0, 8'h33, 8'h40, 11'h405, 1'b1};
    rows[5] = '{12'hbff, 8'h34, 8'h60, 1'b0, 8'h34, 8'h60, 11'h7ff, 1'b1};
    rows[6] = '{12'ha00, 8'h35, 8'h24, 1'b0, 8'h35, 8'h24, 11'h200, 1'b1};
    repeat (2) @(posedge pclk);
    chk(pc_out, 11'h7ff);
    chk(discard_prefetch, 1'b0);
    presetn <= 1'b1;
    rdchk(st_ofs, 32'h18);
    rdchk(acc_ofs, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, {1'b1, rows[i].w[4:0], 2'b00}, {24'h0, rows[i].fv});
      apb(1'b1, st_ofs, {24'h0, rows[i].st});
      apb(1'b1, pc_ofs, 32'h10);
      apb(1'b1, acc_ofs, 32'h5a);
      exe(rows[i].w, 1'b0, 12'h0);
      chk(pc_out, rows[i].ep);
      chk(discard_prefetch, rows[i].edisc);
      @(posedge pclk);
      #1;
      chk(discard_prefetch, 1'b0);
      chk(pc_out, rows[i].ep);
      rdchk(rows[i].dacc ? acc_ofs : {1'b1, rows[i].w[4:0], 2'b00}, rows[i].ed);
      rdchk(st_ofs, rows[i].es);
    end
    apb(1'b1, 8'h84, 32'hff);
    apb(1'b1, 8'h88, 32'h05);
    apb(1'b1, pc_ofs, 32'h10);
    exe(12'h3e1, 1'b1, 12'h2a2);
    chk(pc_out, 11'h012);
    rdchk(8'h88, 32'h05);
    rdchk(8'h84, 32'h0);
    apb(1'b1, st_ofs, 32'h40);
    exe(12'ha05, 1'b1, 12'h2a2);
    chk(pc_out, 11'h405);
    rdchk(8'h88, 32'h05);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b0, 8'h02, 32'h0);
    chk(err, 1'b1);
    // Reset in mid-run must bring back every reset value at once
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk(pc_out, bie_pkg::BIE_PC_RST);
    chk(discard_prefetch, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk(st_ofs, 32'h18);
    rdchk(acc_ofs, 32'h0);
    rdchk(8'h88, 32'h0);
    stop_test();
  end
endmodule : bie_exec_tb

// File: verilog/bie_exec.sv
// Purpose: Executes jump, increment and increment-skip for the 8-bit core.
// Assumes: Fetch pipeline shares pclk and presents one word per cycle.
// Notes: Register file, accumulator, status and counter live here; APB reaches them.
`timescale 1ns/1ps
module bie_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bie_pkg::BIE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [bie_pkg::BIE_WORD_W-1:0] instr_word,
  input wire logic instr_valid,
  output logic [bie_pkg::BIE_PC_W-1:0] pc_out,
  output logic discard_prefetch
);
  typedef struct packed {
    bie_pkg::bie_state_type state;
    logic skip;
    logic kill;
    logic [bie_pkg::BIE_PC_W-1:0] pc;
    logic [bie_pkg::BIE_DATA_W-1:0] acc;
    logic [bie_pkg::BIE_DATA_W-1:0] status;
    logic [bie_pkg::BIE_NREG-1:0][bie_pkg::BIE_DATA_W-1:0] file;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bie_regs_type;

  bie_regs_type st;
  bie_regs_type next_st;

  logic [4:0] f_idx;
  logic dest_file;
  logic is_jump;
  logic is_inc;
  logic is_incsz;
  logic [bie_pkg::BIE_DATA_W-1:0] inc_res;
  logic res_zero;
  logic run_go;
  logic apb_wr;
  logic [4:0] apb_idx;

  assign f_idx = instr_word[4:0];
  assign dest_file = instr_word[bie_pkg::BIE_DEST_BIT];
  assign is_jump = instr_word[11:9] == bie_pkg::BIE_OP_JUMP;
  assign is_inc = instr_word[11:6] == bie_pkg::BIE_OP_INC;
  assign is_incsz = instr_word[11:6] == bie_pkg::BIE_OP_INCSZ;
  assign inc_res = st.file[f_idx] + bie_pkg::BIE_INC_STEP;
  assign res_zero = inc_res == bie_pkg::BIE_ZERO;
  assign run_go = instr_valid && (st.state == bie_pkg::BIE_RUN);
  assign apb_wr = psel && penable && st.pready && pwrite && !st.pslverr;
  assign apb_idx = paddr[6:2];

  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    // Error flag pulses with pready so it never outlives its own answer
    next_st.pslverr = 1'b0;
    // Read data is captured in the setup cycle, so pready can come from a flop
    if (psel && !penable) begin
      next_st.pready = 1'b1;
      next_st.pslverr = 1'b0;
      next_st.prdata = '0;
      if (paddr[1:0] != 2'h0) begin
        next_st.pslverr = 1'b1;
      end else if (paddr[bie_pkg::BIE_FILE_SEL_BIT]) begin
        next_st.prdata[bie_pkg::BIE_DATA_W-1:0] = st.file[apb_idx];
      end else if (paddr == bie_pkg::BIE_OFS_ACC) begin
        next_st.prdata[bie_pkg::BIE_DATA_W-1:0] = st.acc;
      end else if (paddr == bie_pkg::BIE_OFS_STATUS) begin
        next_st.prdata[bie_pkg::BIE_DATA_W-1:0] = st.status;
      end else if (paddr == bie_pkg::BIE_OFS_PC) begin
        next_st.prdata[bie_pkg::BIE_PC_W-1:0] = st.pc;
      end else if (paddr == bie_pkg::BIE_OFS_EXEC) begin
        next_st.prdata[1:0] = {st.skip, st.kill};
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
    if (apb_wr) begin
      if (paddr[bie_pkg::BIE_FILE_SEL_BIT]) begin
        next_st.file[apb_idx] = pwdata[bie_pkg::BIE_DATA_W-1:0];
      end else if (paddr == bie_pkg::BIE_OFS_ACC) begin
        next_st.acc = pwdata[bie_pkg::BIE_DATA_W-1:0];
      end else if (paddr == bie_pkg::BIE_OFS_STATUS) begin
        next_st.status = pwdata[bie_pkg::BIE_DATA_W-1:0];
      end else if (paddr == bie_pkg::BIE_OFS_PC) begin
        next_st.pc = pwdata[bie_pkg::BIE_PC_W-1:0];
      end
    end
    // Execution is applied after the bus so a same-cycle clash leaves the core's result
    case (st.state)
      bie_pkg::BIE_RUN: begin
        if (instr_valid) begin
          next_st.pc = st.pc + bie_pkg::BIE_PC_STEP;
          if (is_jump) begin
            next_st.pc[8:0] = instr_word[8:0];
            next_st.pc[10:9] = st.status[bie_pkg::BIE_PAGE_HI:bie_pkg::BIE_PAGE_LO];
            next_st.state = bie_pkg::BIE_DISCARD;
            next_st.kill = 1'b1;
            next_st.skip = 1'b0;
          end else if (is_inc || is_incsz) begin
            if (dest_file) begin
              next_st.file[f_idx] = inc_res;
            end else begin
              next_st.acc = inc_res;
            end
            if (is_inc) begin
              next_st.status[bie_pkg::BIE_ZERO_BIT] = res_zero;
            end else if (res_zero) begin
              next_st.state = bie_pkg::BIE_DISCARD;
              next_st.kill = 1'b1;
              next_st.skip = 1'b1;
            end
          end
        end
      end
      bie_pkg::BIE_DISCARD: begin
        // The word fetched behind a jump or skip is dropped and runs as a no-op
        next_st.state = bie_pkg::BIE_RUN;
        next_st.kill = 1'b0;
        next_st.skip = 1'b0;
        if (st.skip && instr_valid) begin
          next_st.pc = st.pc + bie_pkg::BIE_PC_STEP;
        end
      end
      default: begin
        next_st.state = bie_pkg::BIE_RUN;
        next_st.kill = 1'b0;
        next_st.skip = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.state <= bie_pkg::BIE_RUN;
      st.pc <= bie_pkg::BIE_PC_RST;
      st.acc <= bie_pkg::BIE_ACC_RST;
      st.status <= bie_pkg::BIE_STATUS_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pc_out = st.pc;
  assign discard_prefetch = st.kill;

  logic status_wr;
  assign status_wr = apb_wr && !paddr[bie_pkg::BIE_FILE_SEL_BIT] && (paddr == bie_pkg::BIE_OFS_STATUS);

  default clocking bie_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence jump_issue_s;
    run_go && is_jump;
  endsequence

  sequence two_cycle_s;
    (st.state == bie_pkg::BIE_DISCARD) && st.kill ##1 (st.state == bie_pkg::BIE_RUN) && !st.kill;
  endsequence

  jump_decode_a: assert property (jump_issue_s |=> st.state == bie_pkg::BIE_DISCARD)
    else $error("jump not decoded");
  jump_low_a: assert property (jump_issue_s |=> pc_out[8:0] == $past(instr_word[8:0]))
    else $error("jump target not loaded");
  jump_page_a: assert property (run_go && is_jump |=> pc_out[10:9] == $past(st.status[6:5]))
    else $error("jump page bits wrong");
  jump_cycles_a: assert property (run_go && is_jump && !status_wr
    |=> (st.status == $past(st.status)) and two_cycle_s)
    else $error("jump timing or flags wrong");
  inc_file_a: assert property (run_go && is_inc && dest_file |=> st.file[$past(f_idx)] == $past(inc_res))
    else $error("increment result not stored");
  inc_acc_a: assert property (run_go && (is_inc || is_incsz) && !dest_file |=> st.acc == $past(inc_res))
    else $error("accumulator not written");
  inc_zero_a: assert property (run_go && is_inc |=> st.status[2] == $past(res_zero) && st.state == bie_pkg::BIE_RUN)
    else $error("zero flag or cycle count wrong");
  skip_flags_a: assert property (run_go && is_incsz && !status_wr |=> st.status == $past(st.status))
    else $error("skip changed status");
  skip_discard_a: assert property (run_go && is_incsz && res_zero |=> discard_prefetch ##1 !discard_prefetch)
    else $error("prefetch not discarded");
  skip_single_a: assert property (run_go && is_incsz && !res_zero |=> st.state == bie_pkg::BIE_RUN)
    else $error("nonzero skip took two cycles");
  skip_step_a: assert property (run_go && is_incsz && !res_zero
    |=> pc_out == $past(pc_out) + bie_pkg::BIE_PC_STEP)
    else $error("nonzero skip did not step once");
  skip_store_a: assert property (run_go && is_incsz && dest_file |=> st.file[$past(f_idx)] == $past(inc_res))
    else $error("skip result not stored");
  discard_once_a: assert property (discard_prefetch |=> !discard_prefetch)
    else $error("discard held too long");
  drop_flags_a: assert property (st.state == bie_pkg::BIE_DISCARD && !status_wr
    |=> st.status == $past(st.status))
    else $error("dropped word changed status");

  sequence setup_s;
    psel && !penable;
  endsequence

  // Zero wait states: the answer always comes in the first access cycle
  apb_ready_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  apb_align_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && pready)
    else $error("misaligned access not refused");
  apb_err_data_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
endmodule : bie_exec

// File: verilog/bie_pkg.sv
// Purpose: Constants for the branch and increment execution slice.
// Assumes: 12-bit instruction word, 11-bit program counter, 8-bit data.
// Notes: Register map is reached over APB with 32-bit aligned words.
// Function
// - Top bits 101 decode as jump, 9-bit target.
// - Jump loads target into counter bits 8:0.
// - Jump loads counter bits 10:9 from status 6:5.
// - Jump: one word, two cycles, flags unchanged.
// - Increment adds one to register, wraps.
// - Destination bit picks accumulator or register.
// - Increment takes one cycle, updates zero flag.
// - Increment-skip increments, leaves all flags alone.
// - Zero result discards prefetched word, runs no-op.
// - Increment-skip: one cycle, two when skipping.
package bie_pkg;
  localparam int BIE_ADDR_W = 8;
  localparam int BIE_PC_W = 11;
  localparam int BIE_DATA_W = 8;
  localparam int BIE_WORD_W = 12;
  localparam int BIE_NREG = 32;

  // Opcode fields
  localparam logic [2:0] BIE_OP_JUMP = 3'h5;
  localparam logic [5:0] BIE_OP_INC = 6'h0a;
  localparam logic [5:0] BIE_OP_INCSZ = 6'h0f;
  localparam int BIE_DEST_BIT = 5;
  localparam int BIE_PAGE_HI = 6;
  localparam int BIE_PAGE_LO = 5;
  localparam int BIE_ZERO_BIT = 2;

  localparam logic [BIE_PC_W-1:0] BIE_PC_STEP = 11'h001;
  localparam logic [BIE_DATA_W-1:0] BIE_INC_STEP = 8'h01;
  localparam logic [BIE_DATA_W-1:0] BIE_ZERO = 8'h00;

  // Register map, byte addresses
  localparam logic [BIE_ADDR_W-1:0] BIE_OFS_ACC = 8'h00;
  localparam logic [BIE_ADDR_W-1:0] BIE_OFS_STATUS = 8'h04;
  localparam logic [BIE_ADDR_W-1:0] BIE_OFS_PC = 8'h08;
  localparam logic [BIE_ADDR_W-1:0] BIE_OFS_EXEC = 8'h0c;
  localparam int BIE_FILE_SEL_BIT = 7;

  // Reset values
  localparam logic [BIE_PC_W-1:0] BIE_PC_RST = 11'h7ff;
  localparam logic [BIE_DATA_W-1:0] BIE_ACC_RST = 8'h00;
  localparam logic [BIE_DATA_W-1:0] BIE_STATUS_RST = 8'h18;

  typedef enum logic [1:0] {
    BIE_RUN = 2'h1,
    BIE_DISCARD = 2'h2
  } bie_state_type;
endpackage : bie_pkg
